/* rtl/hac_pkg.sv */
package hac_pkg;

    // Register indexes in bank 0
    localparam logic [7:0] IDX_TONE_EN2  = 8'h57;
    localparam logic [7:0] IDX_PART_ID   = 8'h58;
    localparam logic [7:0] IDX_DIODE_SEL = 8'h59;
    localparam logic [7:0] IDX_BAT_CFG   = 8'h5D;
    localparam logic [7:0] IDX_CRIT_EN   = 8'h5E;
    localparam logic [2:0] BANK_THIS     = 3'h0;

    // Field positions of the alarm-tone enable register
    localparam int TONE_GATE_BIT      = 7;
    localparam int TONE_INTRUSION_BIT = 4;
    localparam int TONE_VOLT_TWO_BIT  = 1;
    localparam int TONE_VOLT_ONE_BIT  = 0;

    // Field positions of the diode mode register
    localparam int DIODE_PROC_BIT = 5;
    localparam int DIODE_SYS_BIT  = 4;

    // Field positions of the battery and sensor config register
    localparam int BAT_PROC_DIV_BIT  = 6;
    localparam int BAT_SYS_DIV_BIT   = 5;
    localparam int BAT_PROC_TYPE_BIT = 2;
    localparam int BAT_SYS_TYPE_BIT  = 1;
    localparam int BAT_EN_BIT        = 0;

    // Field positions of the critical temperature register
    localparam int CRIT_PROC_BIT     = 5;
    localparam int CRIT_SYS_BIT      = 4;
    localparam int CRIT_PROC_CUR_BIT = 2;
    localparam int CRIT_SYS_CUR_BIT  = 1;

    // Reset values; reserved bits keep these values for ever
    localparam logic [7:0] RST_TONE_EN2  = 8'h80;
    localparam logic [7:0] RST_DIODE_SEL = 8'h70;
    localparam logic [7:0] RST_BAT_CFG   = 8'h04;
    localparam logic [7:0] RST_CRIT_EN   = 8'h04;

    // Writable bits of each register
    localparam logic [7:0] MSK_TONE_EN2  = 8'h93;
    localparam logic [7:0] MSK_DIODE_SEL = 8'h30;
    localparam logic [7:0] MSK_BAT_CFG   = 8'h67;
    localparam logic [7:0] MSK_CRIT_EN   = 8'h36;

    localparam logic [7:0] READ_NONE = 8'h00;

    // Tachometer divisor code and divisor widths, and fan duty width
    localparam int DIV_CODE_W = 3;
    localparam int DIVISOR_W  = 8;
    localparam int DUTY_W     = 8;

    // Host request on the indexed port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] bank;
        logic [7:0] index;
        logic [7:0] data;
    } hac_reg_req_s;

    // Alarm conditions reported by the monitor
    typedef struct packed {
        logic intrusion;
        logic voltTwo;
        logic voltOne;
    } hac_alarm_s;

    typedef enum logic [1:0] {
        SENSE_THERMISTOR,
        SENSE_DIODE,
        SENSE_CURRENT
    } hac_sense_e;

    typedef enum logic [1:0] {
        BAT_OFF,
        BAT_ARMED,
        BAT_RUN
    } hac_bat_e;

endpackage : hac_pkg

/* rtl/hac_tach_divisor.sv */
`timescale 1ns/1ps
module hac_tach_divisor
    import hac_pkg::*;
#(
    parameter int CODE_W = DIV_CODE_W,
    parameter int DIV_W  = DIVISOR_W
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [CODE_W-2:0] codeLow,
    input  wire logic              codeMsb,
    output logic      [DIV_W-1:0]  divisor_r
);

    logic [DIV_W-1:0]  divisor_nxt;
    logic [CODE_W-1:0] code;

    always_comb begin
        code        = {codeMsb, codeLow};
        divisor_nxt = DIV_W'(1) << code;
    end

    // Divisor register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divisor_r <= DIV_W'(1);
        end else begin
            divisor_r <= divisor_nxt;
        end
    end

    a_divisor_power: assert property (@(posedge clk) disable iff (rst)
        ##1 divisor_r == (DIV_W'(1) << $past({codeMsb, codeLow})))
        else $error("divisor is not two to the code");

endmodule : hac_tach_divisor

/* rtl/hac_fan_override.sv */
`timescale 1ns/1ps
module hac_fan_override
    import hac_pkg::*;
#(
    parameter int W = DUTY_W
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         protectEn,
    input  wire logic         cruiseMode,
    input  wire logic         tempOver,
    input  wire logic [W-1:0] dutyIn,
    output logic      [W-1:0] drive_r
);

    logic [W-1:0] drive_nxt;

    always_comb begin
        if (protectEn && cruiseMode && tempOver) begin
            drive_nxt = {W{1'b1}};
        end else begin
            drive_nxt = dutyIn;
        end
    end

    // Drive register; idles at zero until the loop supplies a duty
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive_r <= '0;
        end else begin
            drive_r <= drive_nxt;
        end
    end

    a_override_full: assert property (@(posedge clk) disable iff (rst)
        protectEn && cruiseMode && tempOver |=> drive_r == {W{1'b1}})
        else $error("critical protection did not force full drive");

endmodule : hac_fan_override

/* rtl/hac_config_bank.sv */
// Operation
// - Global gate resets on, off silences tone
// - Bit 4 lets intrusion sound tone
// - Bit 1 lets voltage two sound
// - Bit 0 lets voltage one sound
// - Part code read-only, writes ignored
// - Bit 5 processor diode mode
// - Bit 4 system diode mode
// - Bit 6 processor divisor msb, power two
// - Bit 5 system divisor msb, power two
// - Bit 2 processor sensor type, reset diode
// - Bit 1 system sensor type, reset thermistor
// - Battery enable; first update after full cycle
// - Bit 5 processor fan critical protection
// - Bit 4 system fan critical protection
// - Bit 2 processor current mode, reset on
// - Bit 1 system current mode
`timescale 1ns/1ps
module hac_config_bank
    import hac_pkg::*;
#(
    parameter logic [7:0] PART_CODE = 8'h3A  // Arbitrary value
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire hac_reg_req_s         hostReq,
    output logic       [7:0]          readData_r,
    output logic                      readValid_r,
    input  wire hac_alarm_s           alarmSrc,
    output logic                      alarmToneOutput_r,
    output hac_sense_e                procTempSense_r,
    output hac_sense_e                sysTempSense_r,
    input  wire logic [DIV_CODE_W-2:0] procTachDivLow,
    input  wire logic [DIV_CODE_W-2:0] sysTachDivLow,
    output logic      [DIVISOR_W-1:0] procTachDivisor_r,
    output logic      [DIVISOR_W-1:0] sysTachDivisor_r,
    input  wire logic                 monitorCycleEnd,
    input  wire logic [7:0]           batteryReading,
    output logic      [7:0]           batteryValue_r,
    output logic                      batteryMonitorOn_r,
    input  wire logic                 procCruiseMode,
    input  wire logic                 sysCruiseMode,
    input  wire logic                 procTempOverCrit,
    input  wire logic                 sysTempOverCrit,
    input  wire logic [DUTY_W-1:0]    procDutyIn,
    input  wire logic [DUTY_W-1:0]    sysDutyIn,
    output logic      [DUTY_W-1:0]    procFanDrive_r,
    output logic      [DUTY_W-1:0]    sysFanDrive_r
);

    logic [7:0] toneEn_r,  toneEn_nxt;
    logic [7:0] diodeSel_r, diodeSel_nxt;
    logic [7:0] batCfg_r,  batCfg_nxt;
    logic [7:0] critEn_r,  critEn_nxt;
    logic [7:0] readData_nxt;
    logic       readValid_nxt;
    logic       bankHit;

    // Only bank 0 owns these indexes
    assign bankHit = (hostReq.bank == BANK_THIS);

    // Register writes; reserved bits hold their reset value
    always_comb begin
        toneEn_nxt   = toneEn_r;
        diodeSel_nxt = diodeSel_r;
        batCfg_nxt   = batCfg_r;
        critEn_nxt   = critEn_r;
        if (hostReq.wr && bankHit) begin
            case (hostReq.index)
                IDX_TONE_EN2: begin
                    toneEn_nxt = (hostReq.data & MSK_TONE_EN2) | (RST_TONE_EN2 & ~MSK_TONE_EN2);
                end
                IDX_DIODE_SEL: begin
                    diodeSel_nxt = (hostReq.data & MSK_DIODE_SEL)
                                 | (RST_DIODE_SEL & ~MSK_DIODE_SEL);
                end
                IDX_BAT_CFG: begin
                    batCfg_nxt = (hostReq.data & MSK_BAT_CFG) | (RST_BAT_CFG & ~MSK_BAT_CFG);
                end
                IDX_CRIT_EN: begin
                    critEn_nxt = (hostReq.data & MSK_CRIT_EN) | (RST_CRIT_EN & ~MSK_CRIT_EN);
                end
                default: begin
                    toneEn_nxt = toneEn_r;
                end
            endcase
        end
    end

    // Read path; unmapped index or foreign bank returns zero
    always_comb begin
        readData_nxt  = readData_r;
        readValid_nxt = 1'b0;
        if (hostReq.rd) begin
            readValid_nxt = 1'b1;
            readData_nxt  = READ_NONE;
            if (bankHit) begin
                case (hostReq.index)
                    IDX_TONE_EN2:  readData_nxt = toneEn_r;
                    IDX_PART_ID:   readData_nxt = PART_CODE;
                    IDX_DIODE_SEL: readData_nxt = diodeSel_r;
                    IDX_BAT_CFG:   readData_nxt = batCfg_r;
                    IDX_CRIT_EN:   readData_nxt = critEn_r;
                    default:       readData_nxt = READ_NONE;
                endcase
            end
        end
    end

    // Register file and read answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toneEn_r    <= RST_TONE_EN2;
            diodeSel_r  <= RST_DIODE_SEL;
            batCfg_r    <= RST_BAT_CFG;
            critEn_r    <= RST_CRIT_EN;
            readData_r  <= READ_NONE;
            readValid_r <= 1'b0;
        end else begin
            toneEn_r    <= toneEn_nxt;
            diodeSel_r  <= diodeSel_nxt;
            batCfg_r    <= batCfg_nxt;
            critEn_r    <= critEn_nxt;
            readData_r  <= readData_nxt;
            readValid_r <= readValid_nxt;
        end
    end

    // Alarm tone; registered so the pin never glitches between sources
    logic toneAny;
    logic alarmTone_nxt;
    always_comb begin
        toneAny = (toneEn_r[TONE_INTRUSION_BIT] && alarmSrc.intrusion)
                | (toneEn_r[TONE_VOLT_TWO_BIT] && alarmSrc.voltTwo)
                | (toneEn_r[TONE_VOLT_ONE_BIT] && alarmSrc.voltOne);
        alarmTone_nxt = toneEn_r[TONE_GATE_BIT] && toneAny;
    end

    // Sensing mode per temperature input; current mode overrides the type
    hac_sense_e procSense_nxt;
    hac_sense_e sysSense_nxt;
    always_comb begin
        if (critEn_r[CRIT_PROC_CUR_BIT]) begin
            procSense_nxt = SENSE_CURRENT;
        end else if (batCfg_r[BAT_PROC_TYPE_BIT]) begin
            procSense_nxt = SENSE_DIODE;
        end else begin
            procSense_nxt = SENSE_THERMISTOR;
        end
        if (critEn_r[CRIT_SYS_CUR_BIT]) begin
            sysSense_nxt = SENSE_CURRENT;
        end else if (batCfg_r[BAT_SYS_TYPE_BIT]) begin
            sysSense_nxt = SENSE_DIODE;
        end else begin
            sysSense_nxt = SENSE_THERMISTOR;
        end
    end

    // Tone and sense registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alarmToneOutput_r <= 1'b0;
            procTempSense_r   <= SENSE_CURRENT;
            sysTempSense_r    <= SENSE_THERMISTOR;
        end else begin
            alarmToneOutput_r <= alarmTone_nxt;
            procTempSense_r   <= procSense_nxt;
            sysTempSense_r    <= sysSense_nxt;
        end
    end

    // Diode mode bits are decoded into internal signals that drive no output; 0 is reserved,
    // so software must leave them at 1 when a diode sensor is fitted.
    logic procDiodeCompat;
    logic sysDiodeCompat;
    assign procDiodeCompat = diodeSel_r[DIODE_PROC_BIT];
    assign sysDiodeCompat  = diodeSel_r[DIODE_SYS_BIT];

    // Battery monitor; a cycle already running at enable is discarded
    hac_bat_e   batState_r, batState_nxt;
    logic [7:0] batValue_nxt;
    logic       batOn_nxt;
    always_comb begin
        batState_nxt = batState_r;
        batValue_nxt = batteryValue_r;
        batOn_nxt    = batCfg_r[BAT_EN_BIT];
        case (batState_r)
            BAT_OFF: begin
                if (batCfg_r[BAT_EN_BIT]) begin
                    batState_nxt = BAT_ARMED;
                end
            end
            BAT_ARMED: begin
                if (!batCfg_r[BAT_EN_BIT]) begin
                    batState_nxt = BAT_OFF;
                end else if (monitorCycleEnd) begin
                    batState_nxt = BAT_RUN;
                end
            end
            BAT_RUN: begin
                if (!batCfg_r[BAT_EN_BIT]) begin
                    batState_nxt = BAT_OFF;
                end else if (monitorCycleEnd) begin
                    batValue_nxt = batteryReading;
                end
            end
            default: begin
                batState_nxt = BAT_OFF;
            end
        endcase
    end

    // Battery registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            batState_r         <= BAT_OFF;
            batteryValue_r     <= 8'h00;
            batteryMonitorOn_r <= 1'b0;
        end else begin
            batState_r         <= batState_nxt;
            batteryValue_r     <= batValue_nxt;
            batteryMonitorOn_r <= batOn_nxt;
        end
    end

    hac_tach_divisor u_procDiv (
        .clk       (clk),
        .rst       (rst),
        .codeLow   (procTachDivLow),
        .codeMsb   (batCfg_r[BAT_PROC_DIV_BIT]),
        .divisor_r (procTachDivisor_r)
    );

    hac_tach_divisor u_sysDiv (
        .clk       (clk),
        .rst       (rst),
        .codeLow   (sysTachDivLow),
        .codeMsb   (batCfg_r[BAT_SYS_DIV_BIT]),
        .divisor_r (sysTachDivisor_r)
    );

    hac_fan_override u_procFan (
        .clk        (clk),
        .rst        (rst),
        .protectEn  (critEn_r[CRIT_PROC_BIT]),
        .cruiseMode (procCruiseMode),
        .tempOver   (procTempOverCrit),
        .dutyIn     (procDutyIn),
        .drive_r    (procFanDrive_r)
    );

    hac_fan_override u_sysFan (
        .clk        (clk),
        .rst        (rst),
        .protectEn  (critEn_r[CRIT_SYS_BIT]),
        .cruiseMode (sysCruiseMode),
        .tempOver   (sysTempOverCrit),
        .dutyIn     (sysDutyIn),
        .drive_r    (sysFanDrive_r)
    );

    // Checks
    sequence seqArmedBoundary;
        batState_r == BAT_ARMED && batCfg_r[BAT_EN_BIT] && monitorCycleEnd;
    endsequence

    sequence seqRunSample;
        batState_r == BAT_RUN && batCfg_r[BAT_EN_BIT] && monitorCycleEnd;
    endsequence

    a_tone_gate_off: assert property (@(posedge clk) disable iff (rst)
        !toneEn_r[TONE_GATE_BIT] |=> !alarmToneOutput_r)
        else $error("tone sounded with gate off");

    a_tone_intrusion: assert property (@(posedge clk) disable iff (rst)
        toneEn_r[TONE_GATE_BIT] && toneEn_r[TONE_INTRUSION_BIT] && alarmSrc.intrusion
        |=> alarmToneOutput_r)
        else $error("intrusion did not sound tone");

    a_tone_volt_two: assert property (@(posedge clk) disable iff (rst)
        toneEn_r[TONE_GATE_BIT] && toneEn_r[TONE_VOLT_TWO_BIT] && alarmSrc.voltTwo
        |=> alarmToneOutput_r)
        else $error("voltage two did not sound tone");

    a_tone_volt_one: assert property (@(posedge clk) disable iff (rst)
        toneEn_r[TONE_GATE_BIT] && toneEn_r[TONE_VOLT_ONE_BIT] && alarmSrc.voltOne
        |=> alarmToneOutput_r)
        else $error("voltage one did not sound tone");

    a_tone_cause: assert property (@(posedge clk) disable iff (rst)
        alarmToneOutput_r |-> $past(toneEn_r[TONE_GATE_BIT]) && $past(toneAny))
        else $error("tone without enabled alarm");

    a_part_code: assert property (@(posedge clk) disable iff (rst)
        hostReq.rd && bankHit && hostReq.index == IDX_PART_ID
        |=> readValid_r && readData_r == PART_CODE)
        else $error("part code read wrong");

    a_proc_current: assert property (@(posedge clk) disable iff (rst)
        critEn_r[CRIT_PROC_CUR_BIT] |=> procTempSense_r == SENSE_CURRENT)
        else $error("processor current mode not selected");

    a_sys_sense: assert property (@(posedge clk) disable iff (rst)
        !critEn_r[CRIT_SYS_CUR_BIT] |=> sysTempSense_r ==
        ($past(batCfg_r[BAT_SYS_TYPE_BIT]) ? SENSE_DIODE : SENSE_THERMISTOR))
        else $error("system sensor type wrong");

    a_bat_first_cycle: assert property (@(posedge clk) disable iff (rst)
        seqArmedBoundary |=> batState_r == BAT_RUN && $stable(batteryValue_r))
        else $error("battery updated before full cycle");

    a_bat_sample: assert property (@(posedge clk) disable iff (rst)
        seqRunSample |=> batteryValue_r == $past(batteryReading))
        else $error("battery reading not taken");

endmodule : hac_config_bank

/* tb/hac_host_model.sv */
`timescale 1ns/1ps
module hac_host_model
    import hac_pkg::*;
(
    input  wire logic       clk,
    output hac_reg_req_s    hostReq,
    input  wire logic [7:0] readData_r,
    input  wire logic       readValid_r
);
    // Port idles quiet until the first request
    initial begin
        hostReq = '0;
    end

    // Write strobe for one edge; released fields show inverted junk, not stale values
    task automatic regWrite(input logic [2:0] bank, input logic [7:0] idx, input logic [7:0] val);
        @(posedge clk);
        #2;
        hostReq = '{wr: 1'b1, rd: 1'b0, bank: bank, index: idx, data: val};
        @(posedge clk);
        #2;
        hostReq = '{wr: 1'b0, rd: 1'b0, bank: ~bank, index: ~idx, data: ~val};
    endtask : regWrite

    // Read strobe for one edge, then a bounded wait for the answer pulse
    task automatic regRead(input logic [2:0] bank, input logic [7:0] idx,
                           output logic [7:0] val, output logic ok);
        @(posedge clk);
        #2;
        hostReq = '{wr: 1'b0, rd: 1'b1, bank: bank, index: idx, data: ~idx};
        @(posedge clk);
        #2;
        hostReq = '{wr: 1'b0, rd: 1'b0, bank: ~bank, index: ~idx, data: idx};
        ok  = 1'b0;
        val = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (readValid_r === 1'b1) begin
                ok  = 1'b1;
                val = readData_r;
            end else begin
                @(posedge clk);
                #2;
            end
        end
    endtask : regRead
endmodule : hac_host_model

/* tb/test_hac_config_bank.sv */
`timescale 1ns/1ps
module test_hac_config_bank
    import hac_pkg::*;
;
    localparam logic [7:0] PART_ID = 8'h6B;  // Arbitrary value

    logic         clk;
    logic         rst;
    hac_reg_req_s hostReq;
    logic [7:0]   readData_r;
    logic         readValid_r;
    hac_alarm_s   alarmSrc;
    logic         tone;
    hac_sense_e   procSense;
    hac_sense_e   sysSense;
    hac_sense_e   expS;
    logic [1:0]   procDivLow;
    logic [1:0]   sysDivLow;
    logic [7:0]   procDiv;
    logic [7:0]   sysDiv;
    logic         cycleEnd;
    logic [7:0]   batReading;
    logic [7:0]   batValue;
    logic         batOn;
    logic         procCruise;
    logic         sysCruise;
    logic         procOver;
    logic         sysOver;
    logic [7:0]   procDuty;
    logic [7:0]   sysDuty;
    logic [7:0]   procDrive;
    logic [7:0]   sysDrive;
    logic [7:0]   rdData;
    logic         ok;
    int           failCount;
    int           checksDone;
    logic [7:0]   idxTab  [4] = '{8'h57, 8'h59, 8'h5D, 8'h5E};
    logic [7:0]   onesTab [4] = '{8'h93, 8'h70, 8'h67, 8'h36};
    logic [7:0]   zeroTab [4] = '{8'h00, 8'h40, 8'h00, 8'h00};
    logic [7:0]   toneBit [3] = '{8'h01, 8'h02, 8'h10};

    hac_config_bank #(.PART_CODE(PART_ID)) DUT (
        .clk(clk), .rst(rst), .hostReq(hostReq), .readData_r(readData_r),
        .readValid_r(readValid_r), .alarmSrc(alarmSrc), .alarmToneOutput_r(tone),
        .procTempSense_r(procSense), .sysTempSense_r(sysSense),
        .procTachDivLow(procDivLow), .sysTachDivLow(sysDivLow),
        .procTachDivisor_r(procDiv), .sysTachDivisor_r(sysDiv),
        .monitorCycleEnd(cycleEnd), .batteryReading(batReading),
        .batteryValue_r(batValue), .batteryMonitorOn_r(batOn),
        .procCruiseMode(procCruise), .sysCruiseMode(sysCruise),
        .procTempOverCrit(procOver), .sysTempOverCrit(sysOver),
        .procDutyIn(procDuty), .sysDutyIn(sysDuty),
        .procFanDrive_r(procDrive), .sysFanDrive_r(sysDrive)
    );

    hac_host_model host (
        .clk(clk), .hostReq(hostReq), .readData_r(readData_r), .readValid_r(readValid_r)
    );

    // 20 MHz clock
    initial clk = 1'b0;
    always #25 clk = ~clk;

    task automatic endOfTest();
        if (failCount == 0 && checksDone > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : endOfTest

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failCount++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // A missing answer pulse ends the run at once
    task automatic readCheck(input logic [2:0] bank, input logic [7:0] idx, input logic [7:0] exp);
        host.regRead(bank, idx, rdData, ok);
        if (ok !== 1'b1) begin
            failCount++;
            endOfTest();
        end else begin
            check("readData", rdData, exp);
        end
    endtask : readCheck

    // Outputs follow one cycle after inputs; two edges leave margin
    task automatic settle();
        repeat (2) @(posedge clk);
        #2;
    endtask : settle

    task automatic pulseEnd(input logic [7:0] v);
        cycleEnd   = 1'b1;
        batReading = v;
        @(posedge clk);
        #2;
        cycleEnd   = 1'b0;
        batReading = ~v;
        settle();
    endtask : pulseEnd

    // Main sequence
    initial begin
        failCount = 0;
        checksDone = 0;
        rst = 1'b1;
        alarmSrc = '0;
        {procDivLow, sysDivLow, cycleEnd, batReading} = '0;
        {procCruise, sysCruise, procOver, sysOver, procDuty, sysDuty} = '0;
        repeat (8) @(posedge clk);
        #2;
        rst = 1'b0;
        check("tone", {7'h0, tone}, 8'h00);
        check("procSense", 8'(procSense), 8'(SENSE_CURRENT));
        check("sysSense", 8'(sysSense), 8'(SENSE_THERMISTOR));
        check("procDiv", procDiv, 8'h01);
        readCheck(BANK_THIS, 8'h57, 8'h80);
        readCheck(BANK_THIS, 8'h58, PART_ID);
        readCheck(BANK_THIS, 8'h59, 8'h70);
        readCheck(BANK_THIS, 8'h5D, 8'h04);
        readCheck(BANK_THIS, 8'h5E, 8'h04);
        // Writable fields only; reserved bits keep their reset values
        for (int i = 0; i < 4; i++) begin
            host.regWrite(BANK_THIS, idxTab[i], 8'hFF);
            readCheck(BANK_THIS, idxTab[i], onesTab[i]);
            host.regWrite(BANK_THIS, idxTab[i], 8'h00);
            readCheck(BANK_THIS, idxTab[i], zeroTab[i]);
        end
        host.regWrite(BANK_THIS, 8'h58, 8'hFF);
        readCheck(BANK_THIS, 8'h58, PART_ID);
        host.regWrite(3'h1, 8'h57, 8'hFF);
        readCheck(BANK_THIS, 8'h57, 8'h00);
        readCheck(BANK_THIS, 8'h5A, 8'h00);
        readCheck(3'h1, 8'h58, 8'h00);
        // Each enable passes only its own source
        for (int k = 0; k < 3; k++) begin
            host.regWrite(BANK_THIS, 8'h57, 8'h80 | toneBit[k]);
            for (int j = 0; j < 3; j++) begin
                alarmSrc = 3'(1 << j);
                settle();
                check("tone", {7'h0, tone}, {7'h0, j == k});
            end
        end
        alarmSrc = 3'h7;
        host.regWrite(BANK_THIS, 8'h57, 8'h13);
        settle();
        check("tone", {7'h0, tone}, 8'h00);
        host.regWrite(BANK_THIS, 8'h57, 8'h80);
        settle();
        check("tone", {7'h0, tone}, 8'h00);
        // Current mode overrides sensor type
        for (int i = 0; i < 4; i++) begin
            host.regWrite(BANK_THIS, 8'h5E, i[1] ? 8'h06 : 8'h00);
            host.regWrite(BANK_THIS, 8'h5D, i[0] ? 8'h06 : 8'h00);
            settle();
            expS = i[1] ? SENSE_CURRENT : (i[0] ? SENSE_DIODE : SENSE_THERMISTOR);
            check("procSense", 8'(procSense), 8'(expS));
            check("sysSense", 8'(sysSense), 8'(expS));
        end
        // Every divisor code; the two fans run opposite codes
        for (int c = 0; c < 8; c++) begin
            host.regWrite(BANK_THIS, 8'h5D, c[2] ? 8'h40 : 8'h20);
            procDivLow = 2'(c);
            sysDivLow  = 2'(7 - c);
            settle();
            check("procDiv", procDiv, 8'(1 << c));
            check("sysDiv", sysDiv, 8'(1 << (7 - c)));
        end
        // Protection bits set one fan at a time
        for (int i = 0; i < 8; i++) begin
            host.regWrite(BANK_THIS, 8'h5E, i[2] ? 8'h20 : 8'h10);
            {procCruise, sysCruise} = {2{i[1]}};
            {procOver, sysOver} = {2{i[0]}};
            procDuty = 8'(i * 16 + 3);
            sysDuty  = 8'(i * 16 + 9);
            settle();
            check("procDrive", procDrive, (i == 7) ? 8'hFF : procDuty);
            check("sysDrive", sysDrive, (i == 3) ? 8'hFF : sysDuty);
        end
        // First cycle end after enabling is a partial cycle
        host.regWrite(BANK_THIS, 8'h5D, 8'h01);
        settle();
        check("batOn", {7'h0, batOn}, 8'h01);
        pulseEnd(8'hA5);
        check("batValue", batValue, 8'h00);
        pulseEnd(8'h3C);
        check("batValue", batValue, 8'h3C);
        host.regWrite(BANK_THIS, 8'h5D, 8'h00);
        pulseEnd(8'h77);
        check("batValue", batValue, 8'h3C);
        check("batOn", {7'h0, batOn}, 8'h00);
        endOfTest();
    end
endmodule : test_hac_config_bank
